// >>> inc/hsc_regs.vh
/*
  Constants of the high-speed counter input allocation block: counter indices,
  counting kinds, terminal numbers and filter timing.
  Assumes a 100 MHz system clock and the macros being included by bare name.
*/
// Operation
// R1: Claimed terminals 0-5 filter at 5 us, terminals 6-7 at 50 us.
// R2: Unclaimed terminals stay ordinary general-purpose inputs.
// R3: Six single-input hardware counters count terminals 0-5, no reset or start.
// R4: Single-input software counters count 0/2/4, reset 1/3/5, start 6/7.
// R5: Up/down counters use up 0/3, down 1/4, reset 2/5, start 6/7.
// R6: Quadrature counters use A/B 0/1 or 3/4, reset 2/5, start 6/7.
// R7: Reset clears on input on, or on input off when polarity inverted.
// R8: Alternate selects turn reset/start counters into hardware counters on 6, 7, 3/4.
// R9: Quadrature counters count 1 edge, or 4 edges when selected.
// R10: Alternate select 2 makes the reset quadrature counter a software one without reset.
// R11: Any comparison instruction in use makes hardware counters software counters.
// R12: Inverted reset polarity makes the reset quadrature hardware counter software.
// R13: Each counted pulse increments or decrements its counter by direction.
// R14: Software values update per pulse; hardware values only on move strobe. The code also zeroes a hardware value at once on its clear input.
// R15: Program must not assign one terminal to more than one function.
// R16: Counters hold 32-bit two's-complement values and wrap at limits.
`ifndef HSC_REGS_VH
`define HSC_REGS_VH
`define HSC_NUM_CNT 21
`define HSC_NUM_TERM 8
`define HSC_CLK_PERIOD_NS 10
`define HSC_FAST_FILTER_NS 5000
`define HSC_SLOW_FILTER_NS 50000
`define HSC_GEN_FILTER_NS 10000
`define HSC_FAST_FILTER_CYC ((`HSC_FAST_FILTER_NS + `HSC_CLK_PERIOD_NS - 1) / `HSC_CLK_PERIOD_NS)
`define HSC_SLOW_FILTER_CYC ((`HSC_SLOW_FILTER_NS + `HSC_CLK_PERIOD_NS - 1) / `HSC_CLK_PERIOD_NS)
`define HSC_GEN_FILTER_CYC ((`HSC_GEN_FILTER_NS + `HSC_CLK_PERIOD_NS - 1) / `HSC_CLK_PERIOD_NS)
`define HSC_FAST_TERM_LAST 5
`define HSC_KIND_SINGLE 2'h0
`define HSC_KIND_TWO 2'h1
`define HSC_KIND_QUAD 2'h2
`define HSC_IDX_QUAD_RST_HW 18
`endif

// >>> rtl/hsc_counter.v
/*
  One 32-bit bidirectional high-speed counter with edge decoding, external
  reset and start gating, and a visible value for hardware or software mode.
  Assumes filtered, synchronised terminal levels on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "hsc_regs.vh"
module hsc_counter (
  input wire clk_i,
  input wire nrst_i,
  input wire a_i,
  input wire b_i,
  input wire r_i,
  input wire s_i,
  input wire [1:0] kind_i,
  input wire quad4_i,
  input wire dir_down_i,
  input wire has_rst_i,
  input wire has_start_i,
  input wire rst_on_fall_i,
  input wire enable_i,
  input wire clear_i,
  input wire hw_i,
  input wire move_i,
  output reg [31:0] value_o,
  output reg down_o
);
  reg a_d;
  reg b_d;
  reg r_d;
  reg [31:0] live;
  reg step;
  reg step_down;
  wire a_rise = a_i & ~a_d;
  wire b_rise = b_i & ~b_d;
  wire a_chg = a_i ^ a_d;
  wire b_chg = b_i ^ b_d;
  wire run = enable_i & (~has_start_i | s_i);
  wire rst_ev = has_rst_i & (rst_on_fall_i ? (~r_i & r_d) : (r_i & ~r_d)); // R7
  wire [31:0] next_live = step_down ? live - 32'h00000001 : live + 32'h00000001; // R16

  // Decodes a count step from the terminal edges and its direction from dir_down_i or the terminals.
  always @* begin
    step = 1'h0;
    step_down = 1'h0;
    case (kind_i)
      `HSC_KIND_SINGLE: begin
        step = a_rise;
        step_down = dir_down_i;
      end
      `HSC_KIND_TWO: begin
        step = a_rise ^ b_rise;
        step_down = b_rise;
      end
      `HSC_KIND_QUAD: begin
        if (quad4_i) begin
          step = a_chg ^ b_chg; // R9
          step_down = ~(a_i ^ b_d);
        end else begin
          step = a_rise; // R9
          step_down = b_i;
        end
      end
      default: begin
        step = 1'h0;
        step_down = 1'h0;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      a_d <= 1'h0;
      b_d <= 1'h0;
      r_d <= 1'h0;
      live <= 32'h00000000;
      value_o <= 32'h00000000;
      down_o <= 1'h0;
    end else begin
      a_d <= a_i;
      b_d <= b_i;
      r_d <= r_i;
      if (clear_i || rst_ev) begin
        live <= 32'h00000000; // R7
      end else if (run && step) begin
        live <= next_live; // R13
        down_o <= step_down;
      end
      if (clear_i) begin
        value_o <= 32'h00000000;
      end else if (!hw_i) begin
        value_o <= (rst_ev) ? 32'h00000000 : ((run && step) ? next_live : live); // R14
      end else if (move_i) begin
        value_o <= live; // R14
      end
    end
  end
endmodule // hsc_counter
`default_nettype wire

// >>> rtl/hsc_input_alloc.v
/*
  High-speed counter block: terminal synchronisers and input filters,
  allocation of the eight terminals to twenty-one counters, alternate and
  mode switching, and the visible counter values.
  Assumes control bits come from program logic on the same clock and the
  terminals come asynchronously from outside.
*/
`timescale 1ns/1ns
`default_nettype none
`include "hsc_regs.vh"
module hsc_input_alloc #(
  parameter integer SLOW_FILTER_CYCLES = `HSC_SLOW_FILTER_CYC
) (
  input wire CLK_I,
  input wire NRST_I,
  input wire [7:0] INPUT_TERMINAL_I,
  input wire [20:0] CNT_ENABLE_I,
  input wire [20:0] CNT_CLEAR_I,
  input wire [20:0] CNT_MOVE_I,
  input wire [10:0] CNT_DIR_DOWN_I,
  input wire FUNCTION_CHANGE_CONTACT_I,
  input wire RESET_LOGIC_SELECT_I,
  input wire ALT_SELECT_0_I,
  input wire ALT_SELECT_1_I,
  input wire ALT_SELECT_2_I,
  input wire QUAD_EDGE_SELECT_0_I,
  input wire QUAD_EDGE_SELECT_1_I,
  input wire COMPARE_SET_INSTR_I,
  input wire COMPARE_RESET_INSTR_I,
  input wire ZONE_COMPARE_INSTR_I,
  input wire TABLE_COMPARE_INSTR_I,
  input wire [4:0] CNT_SEL_I,
  output reg [31:0] VALUE_O,
  output reg [20:0] SW_MODE_O,
  output wire [20:0] DIR_DOWN_O,
  output reg [7:0] GENERAL_INPUT_O,
  output reg [7:0] TERMINAL_CLAIMED_O
);
  // Filter lengths in clock cycles.
  localparam integer FAST_CYC = `HSC_FAST_FILTER_CYC;
  localparam integer GEN_CYC = `HSC_GEN_FILTER_CYC;

  // Each switch acts only while the function change contact is driven.
  wire alt0 = FUNCTION_CHANGE_CONTACT_I & ALT_SELECT_0_I;
  wire alt1 = FUNCTION_CHANGE_CONTACT_I & ALT_SELECT_1_I;
  wire alt2 = FUNCTION_CHANGE_CONTACT_I & ALT_SELECT_2_I;
  wire rst_inv = FUNCTION_CHANGE_CONTACT_I & RESET_LOGIC_SELECT_I;
  wire quad4_0 = FUNCTION_CHANGE_CONTACT_I & QUAD_EDGE_SELECT_0_I;
  wire quad4_1 = FUNCTION_CHANGE_CONTACT_I & QUAD_EDGE_SELECT_1_I;
  wire cmp_used = COMPARE_SET_INSTR_I | COMPARE_RESET_INSTR_I | ZONE_COMPARE_INSTR_I | TABLE_COMPARE_INSTR_I;

  reg [62:0] a_idx;
  reg [62:0] b_idx;
  reg [62:0] r_idx;
  reg [62:0] s_idx;
  reg [41:0] kind;
  reg [20:0] has_rst;
  reg [20:0] has_start;
  reg [20:0] quad4;
  reg [20:0] hw;
  reg [7:0] claim;
  reg [2:0] ka;
  reg [2:0] kb;
  reg [2:0] kr;
  reg [2:0] ks;
  reg [1:0] kk;
  reg hr;
  reg hs;
  reg hc;
  reg q4;
  integer k;

  // Filtered terminal levels and the visible values of all counters side by side.
  wire [7:0] term_f;
  wire [671:0] val_v;

  // Works out each counter's terminals, kind and handling from the switches.
  always @* begin
    a_idx = 63'h0;
    b_idx = 63'h0;
    r_idx = 63'h0;
    s_idx = 63'h0;
    kind = 42'h0;
    has_rst = 21'h0;
    has_start = 21'h0;
    quad4 = 21'h0;
    hw = 21'h0;
    claim = 8'h00;
    ka = 3'h0;
    kb = 3'h0;
    kr = 3'h0;
    ks = 3'h0;
    kk = `HSC_KIND_SINGLE;
    hr = 1'h0;
    hs = 1'h0;
    hc = 1'h0;
    q4 = 1'h0;
    for (k = 0; k < `HSC_NUM_CNT; k = k + 1) begin
      ka = 3'h0;
      kb = 3'h0;
      kr = 3'h0;
      ks = 3'h0;
      kk = `HSC_KIND_SINGLE;
      hr = 1'h0;
      hs = 1'h0;
      hc = 1'h0;
      q4 = 1'h0;
      case (k)
        // Single-input hardware counters, one terminal each.
        0, 1, 2, 3, 4, 5: begin
          ka = k[2:0]; // R3
          hc = 1'h1;
        end
        // Single-input software counters with a reset terminal.
        6, 7, 8: begin
          ka = {k[1:0] + 2'h2, 1'h0}; // R4
          kr = {k[1:0] + 2'h2, 1'h1};
          hr = 1'h1;
        end
        // Reset and start counter on 0/1/6, or a hardware counter on 6 when switched.
        9: begin
          if (alt0) begin
            ka = 3'h6; // R8
            hc = 1'h1;
          end else begin
            ka = 3'h0; // R4
            kr = 3'h1;
            ks = 3'h6;
            hr = 1'h1;
            hs = 1'h1;
          end
        end
        // Reset and start counter on 2/3/7, or a hardware counter on 7 when switched.
        10: begin
          if (alt1) begin
            ka = 3'h7; // R8
            hc = 1'h1;
          end else begin
            ka = 3'h2; // R4
            kr = 3'h3;
            ks = 3'h7;
            hr = 1'h1;
            hs = 1'h1;
          end
        end
        // Up/down counters on terminals 0 and 1.
        11, 12, 14: begin
          kk = `HSC_KIND_TWO; // R5
          ka = 3'h0;
          kb = 3'h1;
          kr = 3'h2;
          hc = (k == 11);
          hr = (k != 11);
          ks = 3'h6;
          hs = (k == 14);
        end
        // Up/down counters on terminals 3 and 4.
        13, 15: begin
          kk = `HSC_KIND_TWO; // R5
          ka = 3'h3;
          kb = 3'h4;
          kr = 3'h5;
          ks = 3'h7;
          hs = (k == 15);
          hc = (k == 13) & alt2; // R8
          hr = ~hc;
        end
        // Quadrature counters on terminals 0 and 1.
        16, 17, 19: begin
          kk = `HSC_KIND_QUAD; // R6
          ka = 3'h0;
          kb = 3'h1;
          kr = 3'h2;
          ks = 3'h6;
          hc = (k == 16);
          hr = (k != 16);
          hs = (k == 19);
          q4 = quad4_0; // R9
        end
        // Quadrature counters on terminals 3 and 4.
        18, 20: begin
          kk = `HSC_KIND_QUAD; // R6
          ka = 3'h3;
          kb = 3'h4;
          kr = 3'h5;
          ks = 3'h7;
          hs = (k == 20);
          hr = (k == 20) | ~alt2; // R10
          hc = (k == 18) & ~alt2 & ~rst_inv; // R10 R12
          q4 = quad4_1; // R9
        end
        default: begin
          ka = 3'h0;
        end
      endcase
      a_idx[k*3 +: 3] = ka;
      b_idx[k*3 +: 3] = kb;
      r_idx[k*3 +: 3] = kr;
      s_idx[k*3 +: 3] = ks;
      kind[k*2 +: 2] = kk;
      has_rst[k] = hr;
      has_start[k] = hs;
      quad4[k] = q4;
      // Any comparison instruction in use moves every hardware counter to software.
      hw[k] = hc & ~cmp_used; // R11
      // Marks every terminal that an enabled counter reads.
      if (CNT_ENABLE_I[k]) begin
        claim[ka] = 1'h1;
        if (kk != `HSC_KIND_SINGLE) begin
          claim[kb] = 1'h1;
        end
        if (hr) begin
          claim[kr] = 1'h1;
        end
        if (hs) begin
          claim[ks] = 1'h1;
        end
      end
    end
  end

  genvar t;
  generate
    for (t = 0; t < `HSC_NUM_TERM; t = t + 1) begin : g_term
      localparam integer CLAIM_CYC = (t <= `HSC_FAST_TERM_LAST) ? FAST_CYC : SLOW_FILTER_CYCLES;
      // Two flip-flops bring the terminal into the clock domain.
      reg sync1;
      reg sync2;
      reg filt;
      reg [12:0] cnt;
      // Claimed terminals take the fast or slow constant, others the general one.
      wire [31:0] lim = claim[t] ? CLAIM_CYC : GEN_CYC; // R1
      assign term_f[t] = filt;
      // Passes a level change only after it has stood for the filter time.
      always @(posedge CLK_I) begin
        if (!NRST_I) begin
          sync1 <= 1'h0;
          sync2 <= 1'h0;
          filt <= 1'h0;
          cnt <= 13'h0000;
        end else begin
          sync1 <= INPUT_TERMINAL_I[t];
          sync2 <= sync1;
          if (sync2 == filt) begin
            cnt <= 13'h0000;
          end else if ({19'h00000, cnt} + 32'h00000001 >= lim) begin
            filt <= sync2; // R1
            cnt <= 13'h0000;
          end else begin
            cnt <= cnt + 13'h0001;
          end
        end
      end
    end
  endgenerate

  // One counter per index; an unused terminal select reads terminal 0 harmlessly.
  genvar c;
  generate
    for (c = 0; c < `HSC_NUM_CNT; c = c + 1) begin : g_cnt
      hsc_counter u_cnt (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .a_i(term_f[a_idx[c*3 +: 3]]),
        .b_i(term_f[b_idx[c*3 +: 3]]),
        .r_i(term_f[r_idx[c*3 +: 3]]),
        .s_i(term_f[s_idx[c*3 +: 3]]),
        .kind_i(kind[c*2 +: 2]),
        .quad4_i(quad4[c]),
        .dir_down_i((c < 11) ? CNT_DIR_DOWN_I[(c < 11) ? c : 0] : 1'h0),
        .has_rst_i(has_rst[c]),
        .has_start_i(has_start[c]),
        .rst_on_fall_i(rst_inv),
        .enable_i(CNT_ENABLE_I[c]),
        .clear_i(CNT_CLEAR_I[c]),
        .hw_i(hw[c]),
        .move_i(CNT_MOVE_I[c]),
        .value_o(val_v[c*32 +: 32]),
        .down_o(DIR_DOWN_O[c])
      );
    end
  endgenerate

  // Registers the selected visible value and the mode and claim status.
  always @(posedge CLK_I) begin
    if (!NRST_I) begin
      VALUE_O <= 32'h00000000;
      SW_MODE_O <= 21'h00000;
      GENERAL_INPUT_O <= 8'h00;
      TERMINAL_CLAIMED_O <= 8'h00;
    end else begin
      if (CNT_SEL_I < 5'h15) begin
        VALUE_O <= val_v[CNT_SEL_I*32 +: 32];
      end else begin
        VALUE_O <= 32'h00000000;
      end
      SW_MODE_O <= ~hw;
      // Claimed terminals read as 0 on the general inputs.
      GENERAL_INPUT_O <= term_f & ~claim; // R2
      TERMINAL_CLAIMED_O <= claim;
    end
  end
endmodule // hsc_input_alloc
`default_nettype wire

// >>> testbench/hsc_input_alloc_sva.sv
/* Assertions on the ports of the high-speed counter allocation block.
   Assumes one clock and the synchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module hsc_input_alloc_sva (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic [7:0] INPUT_TERMINAL_I,
  input wire logic [20:0] CNT_ENABLE_I,
  input wire logic [20:0] CNT_CLEAR_I,
  input wire logic [20:0] CNT_MOVE_I,
  input wire logic FUNCTION_CHANGE_CONTACT_I,
  input wire logic RESET_LOGIC_SELECT_I,
  input wire logic ALT_SELECT_0_I,
  input wire logic ALT_SELECT_2_I,
  input wire logic COMPARE_SET_INSTR_I,
  input wire logic COMPARE_RESET_INSTR_I,
  input wire logic ZONE_COMPARE_INSTR_I,
  input wire logic TABLE_COMPARE_INSTR_I,
  input wire logic [4:0] CNT_SEL_I,
  input wire logic [31:0] VALUE_O,
  input wire logic [20:0] SW_MODE_O,
  input wire logic [7:0] GENERAL_INPUT_O,
  input wire logic [7:0] TERMINAL_CLAIMED_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!NRST_I);
  logic cmp;
  logic last7;
  logic [10:0] quiet;
  assign cmp = COMPARE_SET_INSTR_I | COMPARE_RESET_INSTR_I | ZONE_COMPARE_INSTR_I | TABLE_COMPARE_INSTR_I;
  // Counts the cycles that terminal 7 has stood still.
  always_ff @(posedge CLK_I) begin
    last7 <= INPUT_TERMINAL_I[7];
    if (!NRST_I || INPUT_TERMINAL_I[7] != last7) begin
      quiet <= 11'h000;
    end else if (quiet != 11'h7FF) begin
      quiet <= quiet + 11'h001;
    end
  end
  sequence s_idle0;
    CNT_SEL_I == 5'h00 && !CNT_MOVE_I[0] && !CNT_CLEAR_I[0] && !SW_MODE_O[0];
  endsequence
  sequence s_cmp;
    cmp [*3];
  endsequence
  property p_claim_gen;
    (GENERAL_INPUT_O & TERMINAL_CLAIMED_O & $past(TERMINAL_CLAIMED_O)) == 8'h00;
  endproperty
  property p_gen_filter;
    $changed(GENERAL_INPUT_O[7]) && !TERMINAL_CLAIMED_O[7] && !$past(TERMINAL_CLAIMED_O[7]) |-> quiet >= 11'h3E8;
  endproperty
  property p_gen_level;
    !TERMINAL_CLAIMED_O[7] && !$past(TERMINAL_CLAIMED_O[7]) && quiet >= 11'h400 |-> GENERAL_INPUT_O[7] == last7;
  endproperty
  property p_cmp_sw;
    s_cmp |-> SW_MODE_O == 21'h1FFFFF;
  endproperty
  property p_inv_sw;
    (FUNCTION_CHANGE_CONTACT_I && RESET_LOGIC_SELECT_I) [*3] |-> SW_MODE_O[18];
  endproperty
  property p_alt2;
    (FUNCTION_CHANGE_CONTACT_I && ALT_SELECT_2_I && !cmp) [*3] |-> SW_MODE_O[18] && !SW_MODE_O[13];
  endproperty
  property p_alt0;
    (FUNCTION_CHANGE_CONTACT_I && ALT_SELECT_0_I && !cmp) [*3] |-> !SW_MODE_O[9];
  endproperty
  property p_claim0;
    CNT_ENABLE_I[0] [*2] |-> TERMINAL_CLAIMED_O[0];
  endproperty
  property p_hw_hold;
    s_idle0 [*4] |-> $stable(VALUE_O);
  endproperty
  a_claim_gen: assert property (p_claim_gen)
    else $error("claimed terminal seen as general input");
  a_gen_filter: assert property (p_gen_filter)
    else $error("general input changed too early");
  a_gen_level: assert property (p_gen_level)
    else $error("general input does not follow a settled terminal");
  a_cmp_sw: assert property (p_cmp_sw)
    else $error("compare use left a hardware counter");
  a_inv_sw: assert property (p_inv_sw)
    else $error("inverted reset left counter 18 in hardware");
  a_alt2: assert property (p_alt2)
    else $error("alternate select 2 mode wrong");
  a_alt0: assert property (p_alt0)
    else $error("alternate select 0 mode wrong");
  a_claim0: assert property (p_claim0)
    else $error("terminal 0 not claimed");
  a_hw_hold: assert property (p_hw_hold)
    else $error("hardware value moved without move");
endmodule // hsc_input_alloc_sva
bind hsc_input_alloc hsc_input_alloc_sva i_hsc_input_alloc_sva (.CLK_I(CLK_I), .NRST_I(NRST_I),
  .INPUT_TERMINAL_I(INPUT_TERMINAL_I), .CNT_ENABLE_I(CNT_ENABLE_I), .CNT_CLEAR_I(CNT_CLEAR_I),
  .CNT_MOVE_I(CNT_MOVE_I), .FUNCTION_CHANGE_CONTACT_I(FUNCTION_CHANGE_CONTACT_I),
  .RESET_LOGIC_SELECT_I(RESET_LOGIC_SELECT_I), .ALT_SELECT_0_I(ALT_SELECT_0_I), .ALT_SELECT_2_I(ALT_SELECT_2_I),
  .COMPARE_SET_INSTR_I(COMPARE_SET_INSTR_I), .COMPARE_RESET_INSTR_I(COMPARE_RESET_INSTR_I),
  .ZONE_COMPARE_INSTR_I(ZONE_COMPARE_INSTR_I), .TABLE_COMPARE_INSTR_I(TABLE_COMPARE_INSTR_I),
  .CNT_SEL_I(CNT_SEL_I), .VALUE_O(VALUE_O), .SW_MODE_O(SW_MODE_O), .GENERAL_INPUT_O(GENERAL_INPUT_O),
  .TERMINAL_CLAIMED_O(TERMINAL_CLAIMED_O));
`default_nettype wire

// >>> testbench/pulse_source.sv
/* Pulse source model on the eight terminals.
   Assumes the bench clock; idle lines are pulled low. */
`timescale 1ns/1ns
`default_nettype none
module pulse_source (
  input wire logic clk_i,
  output var logic [7:0] term_o
);
  initial term_o = 8'h00;
  // Sets a level and rests longer than any filter.
  task automatic lvl(input int t, input logic v);
    @(negedge clk_i);
    term_o[t] = v;
    repeat (1100) @(negedge clk_i);
  endtask
  task automatic pulse(input int t, input int hi);
    @(negedge clk_i);
    term_o[t] = 1'h1;
    repeat (hi) @(negedge clk_i);
    lvl(t, 1'h0);
  endtask
  // One phase cycle; the leading phase sets the direction.
  task automatic quad(input int a, input int dn);
    lvl(a + dn, 1'h1);
    lvl(a + 1 - dn, 1'h1);
    lvl(a + dn, 1'h0);
    lvl(a + 1 - dn, 1'h0);
  endtask
endmodule // pulse_source
`default_nettype wire

// >>> testbench/high_speed_counter_input_alloc_tb.sv
/* Self-checking bench of the high-speed counter allocation block.
   Assumes the pulse source model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module high_speed_counter_input_alloc_tb;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [20:0] en = 21'h0, clr = 21'h0, mv = 21'h0;
  logic [10:0] dir = 11'h0;
  logic fcc = 1'h0, rls = 1'h0, alt0 = 1'h0, alt1 = 1'h0, alt2 = 1'h0, qe0 = 1'h0, qe1 = 1'h0;
  logic [3:0] cmp = 4'h0;
  logic [4:0] sel = 5'h0;
  logic [7:0] term, gen, claim;
  logic [31:0] value;
  logic [20:0] swm, dn;
  int fails = 0, samples_checked = 0;
  initial forever #5 clk = ~clk;
  pulse_source ps (.clk_i(clk), .term_o(term));
  hsc_input_alloc #(.SLOW_FILTER_CYCLES(20)) i_hsc_input_alloc (.CLK_I(clk), .NRST_I(nrst),
    .INPUT_TERMINAL_I(term), .CNT_ENABLE_I(en), .CNT_CLEAR_I(clr), .CNT_MOVE_I(mv), .CNT_DIR_DOWN_I(dir),
    .FUNCTION_CHANGE_CONTACT_I(fcc), .RESET_LOGIC_SELECT_I(rls), .ALT_SELECT_0_I(alt0), .ALT_SELECT_1_I(alt1),
    .ALT_SELECT_2_I(alt2), .QUAD_EDGE_SELECT_0_I(qe0), .QUAD_EDGE_SELECT_1_I(qe1), .COMPARE_SET_INSTR_I(cmp[0]),
    .COMPARE_RESET_INSTR_I(cmp[1]), .ZONE_COMPARE_INSTR_I(cmp[2]), .TABLE_COMPARE_INSTR_I(cmp[3]),
    .CNT_SEL_I(sel), .VALUE_O(value), .SW_MODE_O(swm), .DIR_DOWN_O(dn), .GENERAL_INPUT_O(gen),
    .TERMINAL_CLAIMED_O(claim));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] k, input logic [31:0] exp);
    @(negedge clk);
    sel = k;
    repeat (2) @(negedge clk);
    chk(value, exp);
  endtask
  task automatic mov(input int k);
    @(negedge clk);
    mv[k] = 1'h1;
    @(negedge clk);
    mv[k] = 1'h0;
  endtask
  task automatic mode(input logic [20:0] exp);
    repeat (3) @(negedge clk);
    chk({11'h0, swm}, {11'h0, exp});
  endtask
  task automatic t_mode;
    mode(21'h1AF7C0);
    fcc = 1'h1;
    alt0 = 1'h1;
    mode(21'h1AF5C0);
    alt0 = 1'h0;
    alt1 = 1'h1;
    mode(21'h1AF3C0);
    alt1 = 1'h0;
    alt2 = 1'h1;
    mode(21'h1ED7C0);
    alt2 = 1'h0;
    rls = 1'h1;
    mode(21'h1EF7C0);
    rls = 1'h0;
    fcc = 1'h0;
    for (int i = 0; i < 4; i++) begin
      cmp = 4'h1 << i;
      mode(21'h1FFFFF);
    end
    cmp = 4'h0;
  endtask
  task automatic t_hw;
    en[0] = 1'h1;
    ps.pulse(0, 600);
    ps.pulse(0, 600);
    ps.pulse(0, 300);
    rd(0, 32'h0);
    mov(0);
    rd(0, 32'h2);
    chk({24'h0, claim}, 32'h1);
    dir[0] = 1'h1;
    ps.pulse(0, 600);
    mov(0);
    rd(0, 32'h1);
    chk({31'h0, dn[0]}, 32'h1);
    clr[0] = 1'h1;
    @(negedge clk);
    clr[0] = 1'h0;
    rd(0, 32'h0);
    ps.pulse(0, 600);
    mov(0);
    rd(0, 32'hFFFFFFFF);
    en[0] = 1'h0;
    dir[0] = 1'h0;
  endtask
  task automatic t_sw;
    en[6] = 1'h1;
    ps.pulse(0, 600);
    ps.pulse(0, 600);
    rd(6, 32'h2);
    ps.pulse(1, 600);
    rd(6, 32'h0);
    fcc = 1'h1;
    rls = 1'h1;
    ps.pulse(0, 600);
    ps.lvl(1, 1'h1);
    rd(6, 32'h1);
    ps.lvl(1, 1'h0);
    rd(6, 32'h0);
    en[6] = 1'h0;
    fcc = 1'h0;
    rls = 1'h0;
  endtask
  task automatic t_two;
    en[11] = 1'h1;
    ps.pulse(0, 600);
    ps.pulse(0, 600);
    ps.pulse(1, 600);
    mov(11);
    rd(11, 32'h1);
    chk({31'h0, dn[11]}, 32'h1);
    en[11] = 1'h0;
  endtask
  task automatic t_quad;
    en[16] = 1'h1;
    ps.quad(0, 0);
    mov(16);
    rd(16, 32'h1);
    chk({31'h0, dn[16]}, 32'h0);
    ps.quad(0, 1);
    mov(16);
    rd(16, 32'h0);
    chk({31'h0, dn[16]}, 32'h1);
    fcc = 1'h1;
    qe0 = 1'h1;
    ps.quad(0, 0);
    mov(16);
    rd(16, 32'h4);
    en[16] = 1'h0;
    qe0 = 1'h0;
    qe1 = 1'h1;
    en[18] = 1'h1;
    ps.quad(3, 0);
    mov(18);
    rd(18, 32'h4);
    en[18] = 1'h0;
    fcc = 1'h0;
    qe1 = 1'h0;
  endtask
  task automatic t_gen;
    ps.lvl(7, 1'h1);
    chk({24'h0, gen}, 32'h80);
    ps.lvl(7, 1'h0);
    en[10] = 1'h1;
    ps.lvl(7, 1'h1);
    chk({24'h0, gen}, 32'h0);
    chk({24'h0, claim}, 32'h8C);
    ps.pulse(2, 600);
    rd(10, 32'h1);
    ps.lvl(7, 1'h0);
    ps.pulse(2, 600);
    rd(10, 32'h1);
    en[10] = 1'h0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'h1;
    @(negedge clk);
    t_mode();
    t_hw();
    t_sw();
    t_two();
    t_quad();
    t_gen();
    complete_run();
  end
  initial begin
    #1000000;
    fails++;
    complete_run();
  end
endmodule // high_speed_counter_input_alloc_tb
`default_nettype wire
